/* File: shared/halt_power_pkg.sv */
// constants for the halt and power-down control block
package halt_power_pkg;
  localparam logic [7:0]  HALT_OPCODE     = 8'h01;   // extra halt instruction
  localparam logic [11:0] RESET_VECTOR    = 12'h000; // restart address
  localparam int          CLOCK_MHZ       = 100;     // core clock rate
  localparam int          SYNC_STAGES     = 3;       // pin synchroniser depth
  localparam logic [7:0]  PORT_RESET_VAL  = 8'hff;   // quasi-bidir ports idle high
  localparam logic [7:0]  BUS_RESET_VAL   = 8'h00;   // bus port latch after reset
endpackage : halt_power_pkg

/* File: src/halt_and_power_down_control.sv */
// halt and power-down control for the single-chip controller core
//
// What this block does
// R1 - opcode 01 decodes as halt instruction
// R2 - halt stops program execution advancing
// R3 - oscillator runs, internal state frozen in halt
// R4 - only reset, interrupt or a power-save entry ends halt
// R5 - reset exit restarts at address zero
// R6 - interrupt exit, enabled: one instruction then vector
// R7 - interrupt exit, disabled: resume after halt opcode
// R8 - ports and test-zero hold values during halt
// R9 - power-save low after reset low: stop, keep RAM
// R10 - supervisor raises power-save then releases reset
// R11 - power-save low after single-step low: stop, keep all
// R12 - raise power-save then single-step; resume exact state
// R13 - reset low 10 ms before, 10 us after
// R14 - single-step low 10 ms before, 10 us after
// R15 - reset, single-step ignored, pull-ups off when stopped
// R16 - test-zero floats, input disabled in power-down
// R17 - halt drives strobes high, address latch low
`timescale 1ns/1ns
module halt_and_power_down_control
  import halt_power_pkg::*;
#(
  parameter int PORT_W = 8                      // port width
) (
  input  wire logic              clock_i,        // core clock, 100 MHz
  input  wire logic              resetn_i,       // async reset, active low
  // pins from the supervisor
  input  wire logic              reset_pin_n_i,  // device reset pin, active low
  input  wire logic              power_save_n_i, // power-save pin, active low
  input  wire logic              single_step_n_i,// single-step pin, active low
  input  wire logic              ext_int_n_i,    // external interrupt, active low
  // core side
  input  wire logic              opcode_valid_i, // core issues an opcode fetch
  input  wire logic [7:0]        opcode_i,       // fetched opcode
  input  wire logic              instr_done_i,   // core completed an instruction
  input  wire logic              interrupts_enabled_state_i, // core interrupt enable
  input  wire logic [PORT_W-1:0] bus_port_core_i,  // bus port value from core
  input  wire logic              bus_port_oe_core_i,// bus port enable from core
  input  wire logic [PORT_W-1:0] port_one_core_i,  // port one value from core
  input  wire logic [PORT_W-1:0] port_two_core_i,  // port two value from core
  input  wire logic              test_zero_core_i, // test-zero value from core
  input  wire logic              test_zero_oe_core_i,// test-zero enable from core
  input  wire logic              test_zero_pin_i,  // test-zero pin input
  input  wire logic              read_strobe_n_core_i,  // core read strobe
  input  wire logic              write_strobe_n_core_i, // core write strobe
  input  wire logic              expander_strobe_core_i,// core expander strobe
  input  wire logic              program_store_strobe_n_core_i, // core fetch strobe
  input  wire logic              addr_latch_core_i,     // core address latch
  // control to core
  output logic                   core_run_o,     // core may advance
  output logic                   core_reset_o,   // core reset and pc load
  output logic [11:0]            restart_addr_o, // pc value on core reset
  output logic                   int_take_o,     // core vectors to service
  output logic                   osc_run_o,      // oscillator enable
  output logic                   pullup_en_o,    // reset/step pull-ups on
  output logic                   halted_o,       // halt mode status
  output logic                   ram_hold_o,     // ram-retention power-down
  output logic                   state_hold_o,   // full-state power-down
  // pins toward the board
  output logic [PORT_W-1:0]      bus_port_o,     // bus port drive value
  output logic                   bus_port_oe_o,  // bus port enable
  output logic [PORT_W-1:0]      port_one_o,     // port one latch
  output logic [PORT_W-1:0]      port_two_o,     // port two latch
  output logic                   port_oe_o,      // quasi-bidir ports driven
  output logic                   test_zero_pin_o,  // test-zero drive
  output logic                   test_zero_pin_oe_o,// test-zero enable
  output logic                   test_zero_in_o,   // test-zero to core
  output logic                   read_strobe_n_o,  // read strobe
  output logic                   write_strobe_n_o, // write strobe
  output logic                   expander_strobe_o,// expander strobe
  output logic                   program_store_strobe_n_o, // fetch strobe
  output logic                   addr_latch_o,     // address latch strobe
  output logic                   strobe_oe_o       // strobes driven
);

  typedef enum logic [2:0] {
    RUN, HALT, STEP_ONE, RAM_DOWN, STATE_DOWN
  } mode_e;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic rst_n_s;
  logic ps_n_s;
  logic ss_n_s;
  logic int_n_s;
  logic t0_s;

  pin_sync #(.RESET_VAL(1'b0)) u_rst (.clock_i(clock_i), .resetn_i(resetn_i),
    .pin_i(reset_pin_n_i), .level_o(rst_n_s));
  pin_sync #(.RESET_VAL(1'b1)) u_ps (.clock_i(clock_i), .resetn_i(resetn_i),
    .pin_i(power_save_n_i), .level_o(ps_n_s));
  pin_sync #(.RESET_VAL(1'b1)) u_ss (.clock_i(clock_i), .resetn_i(resetn_i),
    .pin_i(single_step_n_i), .level_o(ss_n_s));
  pin_sync #(.RESET_VAL(1'b1)) u_int (.clock_i(clock_i), .resetn_i(resetn_i),
    .pin_i(ext_int_n_i), .level_o(int_n_s));
  pin_sync #(.RESET_VAL(1'b0)) u_t0 (.clock_i(clock_i), .resetn_i(resetn_i),
    .pin_i(test_zero_pin_i), .level_o(t0_s));

  ////////////////////////////////////////////////////////////////////////////
  // state and frozen pin copies
  mode_e             mode_r;
  mode_e             mode_nxt;
  logic [PORT_W-1:0] bus_hold_r;
  logic              bus_oe_hold_r;
  logic [PORT_W-1:0] p1_hold_r;
  logic [PORT_W-1:0] p2_hold_r;
  logic              t0_hold_r;
  logic              t0_oe_hold_r;
  logic              int_take_r;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire halt_fetch = opcode_valid_i && (opcode_i == HALT_OPCODE);      // [R1]
  wire osc_stop   = (mode_r == RAM_DOWN) || (mode_r == STATE_DOWN);
  wire pin_reset  = !rst_n_s && !osc_stop;                           // [R15]
  wire int_active = !int_n_s;
  wire enter_ram  = !ps_n_s && !rst_n_s;                             // [R9]
  wire enter_full = !ps_n_s && !ss_n_s && rst_n_s;                   // [R11]

  // next-mode selection; power-save entries take priority over halt
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      RUN: begin
        if (enter_ram) mode_nxt = RAM_DOWN;
        else if (enter_full) mode_nxt = STATE_DOWN;
        else if (halt_fetch) mode_nxt = HALT;                        // [R2]
      end
      HALT: begin
        if (enter_ram) mode_nxt = RAM_DOWN;
        else if (enter_full) mode_nxt = STATE_DOWN;
        else if (pin_reset) mode_nxt = RUN;                          // [R4] [R5]
        else if (int_active && interrupts_enabled_state_i)
          mode_nxt = STEP_ONE;                                       // [R6]
        else if (int_active) mode_nxt = RUN;                         // [R7]
      end
      STEP_ONE: begin
        if (pin_reset || instr_done_i) mode_nxt = RUN;               // [R6]
      end
      RAM_DOWN: begin
        if (ps_n_s) mode_nxt = RUN;                                  // [R10]
      end
      STATE_DOWN: begin
        if (ps_n_s) mode_nxt = RUN;                                  // [R12]
      end
      default: mode_nxt = RUN;
    endcase
  end

  // mode register and interrupt hand-off after the one instruction
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r     <= RUN;
      int_take_r <= 1'b0;
    end else begin
      mode_r     <= mode_nxt;
      int_take_r <= (mode_r == STEP_ONE) && instr_done_i && !pin_reset; // [R6]
    end
  end

  // capture pin values while running so halt can hold them
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_hold_r    <= BUS_RESET_VAL;
      bus_oe_hold_r <= 1'b0;
      p1_hold_r     <= PORT_RESET_VAL;
      p2_hold_r     <= PORT_RESET_VAL;
      t0_hold_r     <= 1'b0;
      t0_oe_hold_r  <= 1'b0;
    end else if (mode_r == RUN) begin                                // [R8]
      bus_hold_r    <= bus_port_core_i;
      bus_oe_hold_r <= bus_port_oe_core_i;
      p1_hold_r     <= port_one_core_i;
      p2_hold_r     <= port_two_core_i;
      t0_hold_r     <= test_zero_core_i;
      t0_oe_hold_r  <= test_zero_oe_core_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  wire halted    = (mode_r == HALT);
  wire frozen    = halted || (mode_r == STATE_DOWN);
  wire pin_float = osc_stop;

  assign halted_o       = halted;
  assign ram_hold_o     = (mode_r == RAM_DOWN);
  assign state_hold_o   = (mode_r == STATE_DOWN);
  assign core_run_o     = !frozen && !osc_stop && ss_n_s;             // [R2] [R3]
  // ram mode always exits through reset; full-state mode never touches core
  assign core_reset_o   = pin_reset || (mode_r == RAM_DOWN);         // [R5] [R10]
  assign restart_addr_o = RESET_VECTOR;                              // [R5]
  assign int_take_o     = int_take_r;
  assign osc_run_o      = !osc_stop;                                 // [R3] [R9] [R11]
  assign pullup_en_o    = !osc_stop;                                 // [R15]

  // halted pins show held values; power-down floats them
  assign bus_port_o     = halted ? bus_hold_r : bus_port_core_i;     // [R8]
  assign bus_port_oe_o  = pin_float ? 1'b0 :
                          (halted ? bus_oe_hold_r : bus_port_oe_core_i);
  assign port_one_o     = halted ? p1_hold_r : port_one_core_i;      // [R8]
  assign port_two_o     = halted ? p2_hold_r : port_two_core_i;      // [R8]
  assign port_oe_o      = !pin_float;
  assign test_zero_pin_o    = halted ? t0_hold_r : test_zero_core_i; // [R8]
  assign test_zero_pin_oe_o = pin_float ? 1'b0 :                     // [R16]
                              (halted ? t0_oe_hold_r : test_zero_oe_core_i);
  assign test_zero_in_o     = pin_float ? 1'b0 : t0_s;               // [R16]
  assign read_strobe_n_o    = halted ? 1'b1 : read_strobe_n_core_i;  // [R17]
  assign write_strobe_n_o   = halted ? 1'b1 : write_strobe_n_core_i; // [R17]
  assign expander_strobe_o  = halted ? 1'b1 : expander_strobe_core_i;// [R17]
  assign program_store_strobe_n_o = halted ? 1'b1 : program_store_strobe_n_core_i; // [R17]
  assign addr_latch_o       = halted ? 1'b0 : addr_latch_core_i;     // [R17]
  assign strobe_oe_o        = !pin_float;

endmodule : halt_and_power_down_control

/* File: src/pin_sync.sv */
// three-stage synchroniser that reports a change once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
  parameter logic RESET_VAL = 1'b1            // level held during reset
) (
  input  wire logic clock_i,                  // core clock
  input  wire logic resetn_i,                 // async reset, active low
  input  wire logic pin_i,                    // raw pin level
  output logic      level_o                   // filtered level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  wire  agree = (s2_r == s3_r);

  // shift chain; the first stage feeds only the second
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r    <= RESET_VAL;
      s2_r    <= RESET_VAL;
      s3_r    <= RESET_VAL;
      level_r <= RESET_VAL;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) begin
        level_r <= s3_r;
      end
    end
  end

  assign level_o = level_r;
endmodule : pin_sync

/* File: verification/halt_power_checker.sv */
// assertion checker for the halt and power-down control block
`timescale 1ns/1ns
module halt_power_checker
  import halt_power_pkg::*;
#(
  parameter int PORT_W = 8                                        // port width
) (
  input wire logic clock_i, resetn_i, reset_pin_n_i, ext_int_n_i, // clock, reset, pins
  input wire logic opcode_valid_i, instr_done_i, interrupts_enabled_state_i, // core
  input wire logic [7:0] opcode_i,                                // fetched opcode
  input wire logic core_run_o, core_reset_o, int_take_o, osc_run_o, pullup_en_o, // control
  input wire logic halted_o, ram_hold_o, state_hold_o, port_oe_o, strobe_oe_o, // modes
  input wire logic [11:0] restart_addr_o,                         // restart address
  input wire logic [PORT_W-1:0] bus_port_o, port_one_o, port_two_o, // port values
  input wire logic bus_port_oe_o, test_zero_pin_o, test_zero_pin_oe_o, test_zero_in_o, // pins
  input wire logic read_strobe_n_o, write_strobe_n_o, expander_strobe_o, // strobes
  input wire logic program_store_strobe_n_o, addr_latch_o         // fetch and latch strobes
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  logic powered_down;
  // either power-down mode
  assign powered_down = ram_hold_o || state_hold_o;
  sequence s_quiet; (reset_pin_n_i && ext_int_n_i) [*6]; endsequence
  sequence s_int_exit; halted_o ##1 !halted_o && !core_reset_o && !powered_down; endsequence
  property p_halt_entry; core_run_o && opcode_valid_i && opcode_i == HALT_OPCODE
    |=> halted_o || core_reset_o || powered_down; endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("halt not entered");
  property p_halt_freeze; halted_o |-> !core_run_o && osc_run_o; endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("halt not frozen");
  property p_halt_strobes; halted_o |-> read_strobe_n_o && write_strobe_n_o
    && expander_strobe_o && program_store_strobe_n_o && !addr_latch_o; endproperty
  a_halt_strobes: assert property (p_halt_strobes) else $error("halt strobes wrong");
  property p_halt_pins; halted_o && $past(halted_o) |-> $stable(bus_port_o)
    && $stable(port_one_o) && $stable(port_two_o) && $stable(test_zero_pin_o); endproperty
  a_halt_pins: assert property (p_halt_pins) else $error("pins moved in halt");
  property p_halt_stay; s_quiet ##0 halted_o |=> halted_o || state_hold_o; endproperty
  a_halt_stay: assert property (p_halt_stay) else $error("halt left without cause");
  property p_reset_vec; (!reset_pin_n_i) [*6] |-> (core_reset_o || state_hold_o)
    && !halted_o && restart_addr_o == RESET_VECTOR; endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset exit wrong");
  property p_int_take; int_take_o |-> $past(instr_done_i) && !halted_o; endproperty
  a_int_take: assert property (p_int_take) else $error("vector without step");
  property p_int_dis; s_int_exit ##0 !interrupts_enabled_state_i |-> !int_take_o [*3];
  endproperty
  a_int_dis: assert property (p_int_dis) else $error("vector while disabled");
  property p_ram_down; ram_hold_o |-> !osc_run_o && !pullup_en_o && core_reset_o; endproperty
  a_ram_down: assert property (p_ram_down) else $error("ram power-down wrong");
  property p_state_down; state_hold_o |-> !osc_run_o && !pullup_en_o && !core_run_o
    && !core_reset_o; endproperty
  a_state_down: assert property (p_state_down) else $error("state power-down wrong");
  property p_float; powered_down |-> !(port_oe_o || bus_port_oe_o || strobe_oe_o
    || test_zero_pin_oe_o || test_zero_in_o); endproperty
  a_float: assert property (p_float) else $error("pins driven in power-down");
endmodule : halt_power_checker

/* File: verification/power_supervisor_model.sv */
// behavioural supervisor driving the power-save, reset, step and interrupt pins
`timescale 1ns/1ns
module power_supervisor_model #(
  parameter int SETUP_CYC = 12,      // scaled setup before power-save falls
  parameter int HOLD_CYC  = 6        // scaled hold after power-save rises
) (
  input  wire logic clock_i,         // core clock
  output logic      reset_pin_n_o,   // device reset pin
  output logic      power_save_n_o,  // power-save pin
  output logic      single_step_n_o, // single-step pin
  output logic      ext_int_n_o      // external interrupt pin
);
  // all pins idle high
  initial begin
    {reset_pin_n_o, power_save_n_o, single_step_n_o, ext_int_n_o} = 4'hf;
  end
  // lower the chosen pin, hold it, then drop power-save
  task automatic enter_down(input logic keep_all);
    if (keep_all) single_step_n_o = 1'b0;
    else reset_pin_n_o = 1'b0;
    repeat (SETUP_CYC) @(negedge clock_i);
    power_save_n_o = 1'b0;
  endtask : enter_down
  // restore power-save first, then release the held pin
  task automatic leave_down();
    power_save_n_o = 1'b1;
    repeat (HOLD_CYC) @(negedge clock_i);
    reset_pin_n_o = 1'b1;
    single_step_n_o = 1'b1;
  endtask : leave_down
  // low pulse of n cycles on the interrupt or reset pin
  task automatic pulse(input logic on_int, input int n);
    if (on_int) ext_int_n_o = 1'b0;
    else reset_pin_n_o = 1'b0;
    repeat (n) @(negedge clock_i);
    {ext_int_n_o, reset_pin_n_o} = 2'h3;
  endtask : pulse
endmodule : power_supervisor_model

/* File: verification/test_halt_and_power_down_control.sv */
// self-checking bench for the halt and power-down control block
`timescale 1ns/1ns
module test_halt_and_power_down_control;
  import halt_power_pkg::*;
  logic clock_i = 0, resetn_i = 0, opcode_valid_i = 0, instr_done_i = 0;
  logic reset_pin_n_i, power_save_n_i, single_step_n_i, ext_int_n_i;
  logic interrupts_enabled_state_i = 0, bus_port_oe_core_i = 1, test_zero_core_i = 0;
  logic [7:0] opcode_i = 8'h00, bus_port_core_i = 8'h00, port_one_core_i = 8'h00;
  logic [7:0] port_two_core_i = 8'h00, bus_port_o, port_one_o, port_two_o;
  logic test_zero_oe_core_i = 1, test_zero_pin_i = 0, read_strobe_n_core_i = 0;
  logic write_strobe_n_core_i = 0, expander_strobe_core_i = 0;
  logic program_store_strobe_n_core_i = 0, addr_latch_core_i = 1;
  logic core_run_o, core_reset_o, int_take_o, osc_run_o, pullup_en_o, halted_o, ram_hold_o;
  logic state_hold_o, bus_port_oe_o, port_oe_o, test_zero_pin_o, test_zero_pin_oe_o;
  logic test_zero_in_o, read_strobe_n_o, write_strobe_n_o, expander_strobe_o;
  logic program_store_strobe_n_o, addr_latch_o, strobe_oe_o;
  logic [11:0] restart_addr_o;
  int failures = 0, check_count = 0;
  halt_and_power_down_control uut (.*);
  power_supervisor_model sup (.clock_i, .reset_pin_n_o(reset_pin_n_i),
    .power_save_n_o(power_save_n_i), .single_step_n_o(single_step_n_i),
    .ext_int_n_o(ext_int_n_i));
  // 100 MHz clock
  always #5 clock_i = ~clock_i;
  task automatic tick(input int n); repeat (n) @(negedge clock_i); endtask : tick
  // compare one value and count it
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // bounded wait for halted, ram, state or core reset to reach a level
  task automatic wait_sig(input int s, input logic v);
    logic x;
    for (int n = 0; n < 60; n++) begin
      x = s == 0 ? halted_o : s == 1 ? ram_hold_o : s == 2 ? state_hold_o : core_reset_o;
      if (x === v) return;
      tick(1);
    end
    failures++;
    wrap_up();
  endtask : wait_sig
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // issue one opcode fetch
  task automatic fetch(input logic [7:0] op);
    {opcode_i, opcode_valid_i} = {op, 1'b1};
    tick(1);
    opcode_valid_i = 0;
  endtask : fetch
  // halt, pins held, wake by interrupt with enable ie
  task automatic t_halt_int(input logic ie);
    {interrupts_enabled_state_i, port_one_core_i} = {ie, 8'h5a};
    {port_two_core_i, bus_port_core_i} = 16'h6996;
    tick(6);
    fetch(HALT_OPCODE);
    {port_one_core_i, test_zero_core_i} = {8'ha5, 1'b1};
    {port_two_core_i, bus_port_core_i} = 16'h3cc3;
    {bus_port_oe_core_i, test_zero_oe_core_i} = 2'b00;
    tick(1);
    chk({halted_o, core_run_o, osc_run_o}, 3'b101);
    chk({port_one_o, test_zero_pin_o, bus_port_oe_o, test_zero_pin_oe_o}, 11'h2d3);
    chk({port_two_o, bus_port_o}, 16'h6996);
    chk({read_strobe_n_o, program_store_strobe_n_o, addr_latch_o}, 3'b110);
    chk({write_strobe_n_o, expander_strobe_o}, 2'b11);
    sup.pulse(1, 4);
    wait_sig(0, 0);
    {instr_done_i, test_zero_core_i} = 2'b10;
    {bus_port_oe_core_i, test_zero_oe_core_i} = 2'b11;
    tick(1);
    instr_done_i = 0;
    chk({int_take_o, port_one_o}, {ie, 8'ha5});
    chk({bus_port_oe_o, test_zero_pin_oe_o, port_two_o}, 10'h33c);
    $display("halt wake test done, enable %0d", ie);
  endtask : t_halt_int
  // a plain opcode does not halt; reset leaves halt to the reset vector
  task automatic t_halt_reset();
    fetch(8'h00);
    chk(halted_o, 0);
    tick(1);
    fetch(HALT_OPCODE);
    sup.pulse(0, 6);
    wait_sig(0, 0);
    chk({core_reset_o, restart_addr_o}, 13'h1000);
    wait_sig(3, 0);
    $display("halt reset test done");
  endtask : t_halt_reset
  // enter and leave one power-down mode
  task automatic t_power_down(input logic keep);
    tick(4);
    sup.enter_down(keep);
    wait_sig(keep ? 2 : 1, 1);
    test_zero_pin_i = 1;
    if (keep) sup.pulse(0, 6);
    tick(1);
    chk({osc_run_o, pullup_en_o, port_oe_o, strobe_oe_o, test_zero_in_o}, 5'h00);
    chk({core_reset_o, state_hold_o}, {!keep, keep});
    sup.leave_down();
    wait_sig(keep ? 2 : 1, 0);
    chk(core_reset_o, !keep);
    tick(8);
    chk({core_run_o, core_reset_o, osc_run_o}, 3'b101);
    test_zero_pin_i = 0;
    $display("power-down test done, keep all %0d", keep);
  endtask : t_power_down
  // reset for 8 cycles, then run each scenario
  initial begin
    tick(8);
    resetn_i = 1;
    t_halt_int(0);
    t_halt_int(1);
    t_halt_reset();
    t_power_down(0);
    t_power_down(1);
    wrap_up();
  end
endmodule : test_halt_and_power_down_control
bind halt_and_power_down_control halt_power_checker #(.PORT_W(PORT_W)) chk_i (.*);
